// >>> logic/cplg_pkg.sv
// constants shared by the preset, capture and gate block of one counter channel
// assumes a 32-bit axi4-lite register bus and a single 40 MHz clock
package cplg_pkg;
    localparam int CPLG_DATA_W = 32;
    localparam int CPLG_ADDR_W = 8;
    // register byte addresses
    localparam logic [7:0] CPLG_ADDR_CTRL = 8'h00;
    localparam logic [7:0] CPLG_ADDR_CONFIG = 8'h04;
    localparam logic [7:0] CPLG_ADDR_PRESET = 8'h08;
    localparam logic [7:0] CPLG_ADDR_STATUS = 8'h0c;
    localparam logic [7:0] CPLG_ADDR_COUNTER = 8'h10;
    localparam logic [7:0] CPLG_ADDR_LATCH = 8'h14;
    localparam logic [7:0] CPLG_ADDR_LIMIT_LO = 8'h18;
    localparam logic [7:0] CPLG_ADDR_LIMIT_HI = 8'h1c;
    // control register bits
    localparam int CPLG_CTRL_LATCH_POS = 0;
    localparam int CPLG_CTRL_SET_COUNTER = 1;
    localparam int CPLG_CTRL_LATCH_NEG = 2;
    localparam int CPLG_CTRL_SW_GATE = 3;
    localparam int CPLG_CTRL_PRESET_POS = 4;
    localparam int CPLG_CTRL_PRESET_NEG = 5;
    localparam int CPLG_CTRL_W = 6;
    // config register fields
    localparam int CPLG_CFG_GATE_LSB = 0;
    localparam int CPLG_CFG_CONT_LATCH = 2;
    localparam int CPLG_CFG_W = 3;
    localparam logic [1:0] CPLG_GATE_OFF = 2'h0;
    localparam logic [1:0] CPLG_GATE_HIGH = 2'h1;
    localparam logic [1:0] CPLG_GATE_LOW = 2'h2;
    // status register bits
    localparam int CPLG_ST_LATCH_VALID = 0;
    localparam int CPLG_ST_PRESET_DONE = 1;
    localparam int CPLG_ST_GATE_LEVEL = 2;
    localparam int CPLG_ST_LATCH_LEVEL = 3;
    localparam int CPLG_ST_SW_GATE_VALID = 4;
    localparam int CPLG_ST_OUT_OF_RANGE = 5;
    localparam int CPLG_ST_LOCKED = 6;
    // reset values
    localparam logic [31:0] CPLG_RST_ZERO = 32'h0000_0000;
    localparam logic [31:0] CPLG_RST_LIMIT_HI = 32'hffff_ffff;
    // axi responses
    localparam logic [1:0] CPLG_RESP_OKAY = 2'h0;
    localparam logic [1:0] CPLG_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        CPLG_PRE_IDLE = 4'h1,
        CPLG_PRE_WAIT_POS = 4'h2,
        CPLG_PRE_WAIT_NEG = 4'h4,
        CPLG_PRE_DONE = 4'h8
    } cplg_preset_type;
endpackage

// >>> logic/cplg_top.sv
// preset, capture and gate control around one incremental counter channel
// assumes count pulses already decoded and the gate/latch pin asynchronous
// How it works
// - software set command loads preset into counter
// - any preset load raises preset-done flag
// - preset-done drops once all preset commands clear
// - edge arm bits load preset at chosen edge
// - only first armed preset trigger acts
// - same-edge preset loads before gate locks counting
// - latch arm bits choose rising/falling capture edge
// - capture copies counter into latch value register
// - every capture sets latch-valid flag
// - single mode ignores edges until valid clears
// - continuous mode captures every selected edge
// - in single mode only first capture command honoured until cleared
// - status shows external latch input level
// - same-edge capture stores before gate locks counting
// - gate field: off, lock high, lock low
// - gating off still allows capture from input
// - status shows gate/latch input level
// - out-of-limit preset applied and flagged
// - software gate holds counter and reports valid
`timescale 1ns/1ps
module cplg_top
    import cplg_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic gate_latch_in,
    input wire logic count_up,
    input wire logic count_down,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic counter_locked
);

    function automatic logic [31:0] cplg_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // input synchroniser and edge detection

    logic sync1_reg, sync2_reg, prev_reg;
    logic gl_rise, gl_fall;

    always_ff @(posedge clk) begin
        if (reset) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            sync1_reg <= gate_latch_in;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end
    assign gl_rise = sync2_reg & ~prev_reg;
    assign gl_fall = ~sync2_reg & prev_reg;

    ////////////////////////////////////////////////////////////////////////////
    // register bus

    logic [CPLG_CTRL_W-1:0] ctrl_reg, ctrl_prev_reg;
    logic [CPLG_CFG_W-1:0] cfg_reg;
    logic [31:0] preset_reg, limit_lo_reg, limit_hi_reg;
    logic [31:0] counter_reg, latch_value_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic aw_have_reg, w_have_reg;
    logic do_write;
    logic [31:0] status_word;
    logic latch_valid_reg, out_of_range_reg;
    cplg_preset_type preset_st;

    assign do_write = aw_have_reg & w_have_reg & ~s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= CPLG_RST_ZERO[7:0];
            w_data_reg <= CPLG_RST_ZERO;
            w_strb_reg <= CPLG_RST_ZERO[3:0];
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= CPLG_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_have_reg <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_have_reg <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr_reg == CPLG_ADDR_CTRL || aw_addr_reg == CPLG_ADDR_CONFIG ||
                    aw_addr_reg == CPLG_ADDR_PRESET || aw_addr_reg == CPLG_ADDR_LIMIT_LO ||
                    aw_addr_reg == CPLG_ADDR_LIMIT_HI) begin
                    s_axi_bresp <= CPLG_RESP_OKAY;
                end else begin
                    s_axi_bresp <= CPLG_RESP_SLVERR;
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    logic [31:0] ctrl_merged, cfg_merged;

    assign ctrl_merged = cplg_merge({26'h0, ctrl_reg}, w_data_reg, w_strb_reg);
    assign cfg_merged = cplg_merge({29'h0, cfg_reg}, w_data_reg, w_strb_reg);

    // writable registers; command bits only change through the bus
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_reg <= CPLG_RST_ZERO[CPLG_CTRL_W-1:0];
            cfg_reg <= CPLG_RST_ZERO[CPLG_CFG_W-1:0];
            preset_reg <= CPLG_RST_ZERO;
            limit_lo_reg <= CPLG_RST_ZERO;
            limit_hi_reg <= CPLG_RST_LIMIT_HI;
        end else if (do_write) begin
            if (aw_addr_reg == CPLG_ADDR_CTRL) begin
                ctrl_reg <= ctrl_merged[CPLG_CTRL_W-1:0];
            end else if (aw_addr_reg == CPLG_ADDR_CONFIG) begin
                cfg_reg <= cfg_merged[CPLG_CFG_W-1:0];
            end else if (aw_addr_reg == CPLG_ADDR_PRESET) begin
                preset_reg <= cplg_merge(preset_reg, w_data_reg, w_strb_reg);
            end else if (aw_addr_reg == CPLG_ADDR_LIMIT_LO) begin
                limit_lo_reg <= cplg_merge(limit_lo_reg, w_data_reg, w_strb_reg);
            end else if (aw_addr_reg == CPLG_ADDR_LIMIT_HI) begin
                limit_hi_reg <= cplg_merge(limit_hi_reg, w_data_reg, w_strb_reg);
            end
        end
    end

    always_comb begin
        status_word = CPLG_RST_ZERO;
        status_word[CPLG_ST_LATCH_VALID] = latch_valid_reg;
        status_word[CPLG_ST_PRESET_DONE] = (preset_st == CPLG_PRE_DONE);
        status_word[CPLG_ST_GATE_LEVEL] = sync2_reg;
        status_word[CPLG_ST_LATCH_LEVEL] = sync2_reg;
        status_word[CPLG_ST_SW_GATE_VALID] = ctrl_reg[CPLG_CTRL_SW_GATE];
        status_word[CPLG_ST_OUT_OF_RANGE] = out_of_range_reg;
        status_word[CPLG_ST_LOCKED] = counter_locked;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= CPLG_RST_ZERO;
            s_axi_rresp <= CPLG_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= CPLG_RESP_OKAY;
            if (s_axi_araddr == CPLG_ADDR_CTRL) begin
                s_axi_rdata <= {26'h0, ctrl_reg};
            end else if (s_axi_araddr == CPLG_ADDR_CONFIG) begin
                s_axi_rdata <= {29'h0, cfg_reg};
            end else if (s_axi_araddr == CPLG_ADDR_PRESET) begin
                s_axi_rdata <= preset_reg;
            end else if (s_axi_araddr == CPLG_ADDR_STATUS) begin
                s_axi_rdata <= status_word;
            end else if (s_axi_araddr == CPLG_ADDR_COUNTER) begin
                s_axi_rdata <= counter_reg;
            end else if (s_axi_araddr == CPLG_ADDR_LATCH) begin
                s_axi_rdata <= latch_value_reg;
            end else if (s_axi_araddr == CPLG_ADDR_LIMIT_LO) begin
                s_axi_rdata <= limit_lo_reg;
            end else if (s_axi_araddr == CPLG_ADDR_LIMIT_HI) begin
                s_axi_rdata <= limit_hi_reg;
            end else begin
                s_axi_rdata <= CPLG_RST_ZERO;
                s_axi_rresp <= CPLG_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // preset sequencing

    logic set_cmd, pre_pos_cmd, pre_neg_cmd, lat_pos_cmd, lat_neg_cmd;
    logic set_rise, pre_pos_rise, pre_neg_rise, lat_cmd_rise, preset_fire;

    assign set_cmd = ctrl_reg[CPLG_CTRL_SET_COUNTER];
    assign pre_pos_cmd = ctrl_reg[CPLG_CTRL_PRESET_POS];
    assign pre_neg_cmd = ctrl_reg[CPLG_CTRL_PRESET_NEG];
    assign lat_pos_cmd = ctrl_reg[CPLG_CTRL_LATCH_POS];
    assign lat_neg_cmd = ctrl_reg[CPLG_CTRL_LATCH_NEG];

    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_prev_reg <= CPLG_RST_ZERO[CPLG_CTRL_W-1:0];
        end else begin
            ctrl_prev_reg <= ctrl_reg;
        end
    end
    // a held command acts once; it must drop and rise again to act anew
    assign set_rise = set_cmd & ~ctrl_prev_reg[CPLG_CTRL_SET_COUNTER];
    assign pre_pos_rise = pre_pos_cmd & ~ctrl_prev_reg[CPLG_CTRL_PRESET_POS];
    assign pre_neg_rise = pre_neg_cmd & ~ctrl_prev_reg[CPLG_CTRL_PRESET_NEG];
    assign lat_cmd_rise = (lat_pos_cmd & ~ctrl_prev_reg[CPLG_CTRL_LATCH_POS]) |
                          (lat_neg_cmd & ~ctrl_prev_reg[CPLG_CTRL_LATCH_NEG]);

    // simultaneous arming: software set beats rising edge beats falling edge
    assign preset_fire = (preset_st == CPLG_PRE_IDLE && set_rise) ||
        (preset_st == CPLG_PRE_WAIT_POS && pre_pos_cmd && gl_rise) ||
        (preset_st == CPLG_PRE_WAIT_NEG && pre_neg_cmd && gl_fall);

    always_ff @(posedge clk) begin
        if (reset) begin
            preset_st <= CPLG_PRE_IDLE;
        end else begin
            case (preset_st)
                CPLG_PRE_IDLE: begin
                    if (set_rise) begin
                        preset_st <= CPLG_PRE_DONE;
                    end else if (pre_pos_rise) begin
                        preset_st <= CPLG_PRE_WAIT_POS;
                    end else if (pre_neg_rise) begin
                        preset_st <= CPLG_PRE_WAIT_NEG;
                    end
                end
                CPLG_PRE_WAIT_POS: begin
                    if (preset_fire) begin
                        preset_st <= CPLG_PRE_DONE;
                    end else if (!pre_pos_cmd) begin
                        preset_st <= CPLG_PRE_IDLE;
                    end
                end
                CPLG_PRE_WAIT_NEG: begin
                    if (preset_fire) begin
                        preset_st <= CPLG_PRE_DONE;
                    end else if (!pre_neg_cmd) begin
                        preset_st <= CPLG_PRE_IDLE;
                    end
                end
                CPLG_PRE_DONE: begin
                    if (!set_cmd && !pre_pos_cmd && !pre_neg_cmd) begin
                        preset_st <= CPLG_PRE_IDLE;
                    end
                end
                default: begin
                    preset_st <= CPLG_PRE_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // capture

    logic latch_armed_reg, cap_edge, cap_now, cont_mode;

    assign cont_mode = cfg_reg[CPLG_CFG_CONT_LATCH];
    // capture works whatever the gate mode is
    assign cap_edge = (lat_pos_cmd & gl_rise) | (lat_neg_cmd & gl_fall);
    assign cap_now = cap_edge & (cont_mode | latch_armed_reg);

    always_ff @(posedge clk) begin
        if (reset) begin
            latch_armed_reg <= 1'b0;
            latch_valid_reg <= 1'b0;
            latch_value_reg <= CPLG_RST_ZERO;
        end else begin
            if (!lat_pos_cmd && !lat_neg_cmd) begin
                latch_armed_reg <= 1'b0;
                latch_valid_reg <= 1'b0;
            end else if (cap_now) begin
                latch_armed_reg <= 1'b0;
                latch_valid_reg <= 1'b1;
            end else if (lat_cmd_rise && !latch_valid_reg) begin
                latch_armed_reg <= 1'b1;
            end
            if (cap_now) begin
                latch_value_reg <= counter_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // gate and counter

    logic lock_now;

    always_comb begin
        lock_now = ctrl_reg[CPLG_CTRL_SW_GATE];
        if (cfg_reg[CPLG_CFG_GATE_LSB +: 2] == CPLG_GATE_HIGH) begin
            lock_now = lock_now | sync2_reg;
        end else if (cfg_reg[CPLG_CFG_GATE_LSB +: 2] == CPLG_GATE_LOW) begin
            lock_now = lock_now | ~sync2_reg;
        end
    end

    // preset and capture use the pre-edge count, so they win over the lock
    always_ff @(posedge clk) begin
        if (reset) begin
            counter_reg <= CPLG_RST_ZERO;
            counter_locked <= 1'b0;
        end else begin
            counter_locked <= lock_now;
            if (preset_fire) begin
                counter_reg <= preset_reg;
            end else if (!lock_now && count_up && !count_down) begin
                counter_reg <= counter_reg + 32'h1;
            end else if (!lock_now && count_down && !count_up) begin
                counter_reg <= counter_reg - 32'h1;
            end
        end
    end

    // no clamp on a preset: out-of-limit values stand and are only flagged
    always_ff @(posedge clk) begin
        if (reset) begin
            out_of_range_reg <= 1'b0;
        end else begin
            out_of_range_reg <= (counter_reg < limit_lo_reg) ||
                                (counter_reg > limit_hi_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_preset_load_value: assert property (preset_fire |=> counter_reg == $past(preset_reg))
        else $error("preset value not loaded");
    a_preset_done_flag: assert property (preset_fire |=> status_word[CPLG_ST_PRESET_DONE])
        else $error("preset done not raised");
    a_preset_done_hold: assert property ((preset_st == CPLG_PRE_DONE && set_cmd)
        |=> preset_st == CPLG_PRE_DONE && !preset_fire)
        else $error("preset done dropped or refire");
    a_preset_edge_fire: assert property ((preset_st == CPLG_PRE_WAIT_POS && pre_pos_cmd
        && gl_rise) |=> counter_reg == $past(preset_reg))
        else $error("edge preset missed");
    a_preset_first_only: assert property (preset_st == CPLG_PRE_WAIT_POS && gl_fall
        |-> !preset_fire)
        else $error("second preset trigger acted");
    a_capture_value: assert property (cap_now |=> latch_value_reg == $past(counter_reg))
        else $error("latch value mismatch");
    a_capture_valid: assert property (cap_now |=> latch_valid_reg ##1
        (latch_valid_reg || !(lat_pos_cmd || lat_neg_cmd)))
        else $error("latch valid not set");
    a_single_block: assert property ((!cont_mode && latch_valid_reg) |-> !cap_now)
        else $error("single capture repeated");
    a_gate_hold: assert property ((lock_now && !preset_fire) |=> $stable(counter_reg))
        else $error("counter moved while locked");
    a_sw_gate_status: assert property (ctrl_reg[CPLG_CTRL_SW_GATE] |=> counter_locked)
        else $error("software gate not reflected");

endmodule

// >>> test/cplg_pin_model.sv
// pin and count source standing in for the encoder and the gate/latch wiring
// assumes the bench calls its tasks just after a rising clock edge
`timescale 1ns/1ps
module cplg_pin_model (
    input wire logic clk,
    output logic gate_latch_in,
    output logic count_up,
    output logic count_down
);
    initial begin
        gate_latch_in = 1'b0;
        count_up = 1'b0;
        count_down = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // the pin moves off the clock, then waits out sync, edge compare and action
    task automatic pin(input logic v);
        gate_latch_in <= v;
        repeat (6) @(posedge clk);
    endtask
    // one count per clock while held; a settle gap keeps reads off the last step
    task automatic step(input logic up, input int n);
        count_up <= up;
        count_down <= !up;
        repeat (n) @(posedge clk);
        count_up <= 1'b0;
        count_down <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
endmodule

// >>> test/cplg_top_tb.sv
// self-checking bench for the preset, capture and gate block
// assumes the axi4-lite slave answers in a few cycles and a 40 MHz clock
`timescale 1ns/1ps
module cplg_top_tb import cplg_pkg::*; ;
    logic clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, counter_locked, gl, cu, cd;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [3:0] wstrb;
    int bad_count, total_checks;
    localparam logic [1:0] OK = CPLG_RESP_OKAY;
    localparam logic [31:0] ALL = 32'hffff_ffff;

    cplg_top i_cplg_top (.clk(clk), .reset(reset), .gate_latch_in(gl), .count_up(cu),
        .count_down(cd), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .counter_locked(counter_locked));
    cplg_pin_model i_cplg_pin_model (.clk(clk), .gate_latch_in(gl), .count_up(cu),
        .count_down(cd));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic timeout();
        bad_count++;
        $display("ERROR at %0t: bus answer never came", $time);
        end_of_test();
    endtask
    // each channel is released at the edge its own ready is seen
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n;
        n = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (n == 50) timeout();
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        cmp({30'h0, bresp}, {30'h0, er});
        // commands act a clock after the write lands, so let them settle
        repeat (3) @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] er);
        int n;
        n = 0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (arready) arvalid <= 1'b0;
            if (n == 50) timeout();
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        cmp(rdata & m, e);
        cmp({30'h0, rresp}, {30'h0, er});
        // one edge between reads so rready is never set twice in a step
        @(posedge clk);
    endtask
    task automatic cnt_is(input logic [31:0] e);
        rd(CPLG_ADDR_COUNTER, ALL, e, OK);
    endtask
    task automatic latch_is(input logic [31:0] e);
        rd(CPLG_ADDR_LATCH, ALL, e, OK);
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        reset = 1'b1;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        bad_count = 0;
        total_checks = 0;
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        rd(CPLG_ADDR_LIMIT_HI, ALL, CPLG_RST_LIMIT_HI, OK);
        rd(CPLG_ADDR_STATUS, ALL, 32'h0, OK);
        rd(8'h20, ALL, 32'h0, CPLG_RESP_SLVERR);
        wr(CPLG_ADDR_STATUS, 32'h1, CPLG_RESP_SLVERR);
        note("registers");
        // preset must be in place before the command bit rises
        wr(CPLG_ADDR_LIMIT_HI, 32'h100, OK);
        wr(CPLG_ADDR_PRESET, 32'h1234, OK);
        wr(CPLG_ADDR_CTRL, 32'h2, OK);
        cnt_is(32'h1234);
        rd(CPLG_ADDR_STATUS, 32'h22, 32'h22, OK);
        wr(CPLG_ADDR_CTRL, 32'h0, OK);
        rd(CPLG_ADDR_STATUS, 32'h2, 32'h0, OK);
        wr(CPLG_ADDR_LIMIT_HI, ALL, OK);
        note("software preset");
        wr(CPLG_ADDR_PRESET, 32'h55, OK);
        wr(CPLG_ADDR_CTRL, 32'h30, OK);
        i_cplg_pin_model.pin(1'b1);
        cnt_is(32'h55);
        wr(CPLG_ADDR_PRESET, 32'h77, OK);
        i_cplg_pin_model.pin(1'b0);
        cnt_is(32'h55);
        rd(CPLG_ADDR_STATUS, 32'h2, 32'h2, OK);
        wr(CPLG_ADDR_CTRL, 32'h0, OK);
        wr(CPLG_ADDR_CTRL, 32'h20, OK);
        i_cplg_pin_model.pin(1'b1);
        cnt_is(32'h55);
        i_cplg_pin_model.pin(1'b0);
        cnt_is(32'h77);
        wr(CPLG_ADDR_CTRL, 32'h0, OK);
        note("edge preset");
        i_cplg_pin_model.step(1'b1, 5);
        wr(CPLG_ADDR_CTRL, 32'h1, OK);
        i_cplg_pin_model.pin(1'b1);
        latch_is(32'h7c);
        rd(CPLG_ADDR_STATUS, 32'h1, 32'h1, OK);
        i_cplg_pin_model.step(1'b1, 3);
        wr(CPLG_ADDR_CTRL, 32'h5, OK);
        i_cplg_pin_model.pin(1'b0);
        i_cplg_pin_model.pin(1'b1);
        latch_is(32'h7c);
        wr(CPLG_ADDR_CTRL, 32'h0, OK);
        rd(CPLG_ADDR_STATUS, 32'h1, 32'h0, OK);
        wr(CPLG_ADDR_CTRL, 32'h4, OK);
        i_cplg_pin_model.pin(1'b0);
        latch_is(32'h7f);
        wr(CPLG_ADDR_CTRL, 32'h0, OK);
        wr(CPLG_ADDR_CTRL, 32'h5, OK);
        i_cplg_pin_model.step(1'b0, 2);
        i_cplg_pin_model.pin(1'b1);
        latch_is(32'h7d);
        wr(CPLG_ADDR_CTRL, 32'h0, OK);
        note("single capture");
        wr(CPLG_ADDR_CONFIG, 32'h4, OK);
        wr(CPLG_ADDR_CTRL, 32'h1, OK);
        i_cplg_pin_model.pin(1'b0);
        i_cplg_pin_model.step(1'b1, 4);
        i_cplg_pin_model.pin(1'b1);
        latch_is(32'h81);
        i_cplg_pin_model.step(1'b1, 2);
        i_cplg_pin_model.pin(1'b0);
        i_cplg_pin_model.pin(1'b1);
        latch_is(32'h83);
        wr(CPLG_ADDR_CTRL, 32'h0, OK);
        note("continuous capture");
        // lock while high: pin drops first so counting runs before the edge
        wr(CPLG_ADDR_CONFIG, 32'h1, OK);
        i_cplg_pin_model.pin(1'b0);
        i_cplg_pin_model.step(1'b1, 2);
        wr(CPLG_ADDR_CTRL, 32'h1, OK);
        i_cplg_pin_model.pin(1'b1);
        i_cplg_pin_model.step(1'b1, 4);
        latch_is(32'h85);
        cnt_is(32'h85);
        rd(CPLG_ADDR_STATUS, 32'h4d, 32'h4d, OK);
        cmp({31'h0, counter_locked}, 32'h1);
        i_cplg_pin_model.pin(1'b0);
        wr(CPLG_ADDR_CTRL, 32'h0, OK);
        wr(CPLG_ADDR_CONFIG, 32'h2, OK);
        i_cplg_pin_model.step(1'b1, 3);
        cnt_is(32'h85);
        i_cplg_pin_model.pin(1'b1);
        i_cplg_pin_model.step(1'b1, 3);
        cnt_is(32'h88);
        wr(CPLG_ADDR_PRESET, 32'h9, OK);
        wr(CPLG_ADDR_CTRL, 32'h20, OK);
        i_cplg_pin_model.pin(1'b0);
        i_cplg_pin_model.step(1'b1, 2);
        cnt_is(32'h9);
        wr(CPLG_ADDR_CTRL, 32'h0, OK);
        wr(CPLG_ADDR_CONFIG, 32'h0, OK);
        note("pin gate");
        wr(CPLG_ADDR_CTRL, 32'h8, OK);
        i_cplg_pin_model.step(1'b1, 3);
        cnt_is(32'h9);
        rd(CPLG_ADDR_STATUS, 32'h50, 32'h50, OK);
        wr(CPLG_ADDR_CTRL, 32'h0, OK);
        i_cplg_pin_model.step(1'b1, 3);
        cnt_is(32'hc);
        // only byte lane 1 of the preset may change
        wstrb <= 4'h2;
        wr(CPLG_ADDR_PRESET, 32'haaaa_bbcc, OK);
        wstrb <= 4'hf;
        rd(CPLG_ADDR_PRESET, ALL, 32'h0000_bb09, OK);
        note("software gate");
        end_of_test();
    end
endmodule
